/* File: mdsf_pkg.sv */
// package: status word layout, offset and timing constants for the driver status block
package mdsf_pkg;
  localparam logic [6:0] MDSF_STATUS_ADDR = 7'h6F;
  localparam int MDSF_STST_BIT = 31;
  localparam int MDSF_CHOP_BIT = 30;
  localparam int MDSF_CS_HI = 20;
  localparam int MDSF_CS_LO = 16;
  localparam int MDSF_TEMP_CMP_HIGHEST_BIT = 11;
  localparam int MDSF_TEMP_CMP_HIGH_BIT = 10;
  localparam int MDSF_TEMP_CMP_MID_BIT = 9;
  localparam int MDSF_TEMP_CMP_LOW_BIT = 8;
  localparam int MDSF_OLB_BIT = 7;
  localparam int MDSF_OLA_BIT = 6;
  localparam int MDSF_LSB_BIT = 5;
  localparam int MDSF_LSA_BIT = 4;
  localparam int MDSF_GSB_BIT = 3;
  localparam int MDSF_GSA_BIT = 2;
  localparam int MDSF_OT_BIT = 1;
  localparam int MDSF_OTPW_BIT = 0;
  localparam int MDSF_STST_CYCLES = 1048576;
  localparam logic [31:0] MDSF_STATUS_RESET = 32'h0000_0000;
  localparam logic [4:0] MDSF_OFF_TIME_OFF = 5'h0;
  typedef enum logic [1:0] {
    MDSF_TH_RUN = 2'b00,
    MDSF_TH_SHUT = 2'b01,
    MDSF_TH_COOL = 2'b10
  } mdsf_therm_t;
endpackage

/* File: mdsf_short_if.sv */
// interface: short detections and per-mode latched flags
`timescale 1ns/1ps
interface mdsf_short_if;
  logic [3:0] detect;
  logic chop_quiet;
  logic clear;
  logic [3:0] flags;
  modport owner (input detect, input chop_quiet, input clear, output flags);
  modport user (output detect, output chop_quiet, output clear, input flags);
endinterface

/* File: mdsf_short_latch.sv */
// short flag latches, one set per chopper mode
`timescale 1ns/1ps
module mdsf_short_latch
  import mdsf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  mdsf_short_if.owner sif
);
  logic [3:0] quiet_q;
  logic [3:0] curr_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      quiet_q <= 4'h0;
    end else if (sif.clear) begin
      quiet_q <= 4'h0;
    end else if (sif.chop_quiet) begin
      quiet_q <= quiet_q | sif.detect;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      curr_q <= 4'h0;
    end else if (sif.clear) begin
      curr_q <= 4'h0;
    end else if (!sif.chop_quiet) begin
      curr_q <= curr_q | sif.detect;
    end
  end

  assign sif.flags = sif.chop_quiet ? quiet_q : curr_q;

  latch_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (quiet_q[0] && !sif.clear) |=> quiet_q[0])
    else $error("quiet short flag dropped without clear");
  latch_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    sif.clear |=> (quiet_q == 4'h0 && curr_q == 4'h0))
    else $error("short flags not cleared");
endmodule

/* File: mdsf_status.sv */
// top: driver status word with standstill timer, short latches and thermal shutdown
// Notes on behaviour
// - standstill bit after 2^20 clocks without step
// - bit 30 shows quiet voltage chopper active
// - applied current scale in bits 20:16
// - temperature comparators in bits 11 to 8
// - open load flags bits 7,6, no action
// - low-side short sets bit 5/4, disables bridge
// - ground short sets bit 3/2, disables bridge
// - short flags held until off-time zero or enable_input_n high
// - separate short flag sets per chopper mode
// - overtemp bit 1, bridges off until prewarn clears
// - prewarning bit 0 while threshold exceeded
// - one shared overtemp and prewarning flag
`timescale 1ns/1ps
module mdsf_status
  import mdsf_pkg::*;
#(
  parameter int STST_CYCLES = MDSF_STST_CYCLES
)(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic step_pulse,
  input wire logic chop_quiet,
  input wire logic [4:0] current_scale,
  input wire logic [3:0] temp_cmp,
  input wire logic [1:0] open_load,
  input wire logic [1:0] lowside_short,
  input wire logic [1:0] ground_short,
  input wire logic overtemp_limit,
  input wire logic prewarn_limit,
  input wire logic [4:0] chopper_off_time,
  input wire logic enable_input_n,
  input wire logic rd_en,
  input wire logic [6:0] rd_addr,
  output logic [31:0] rd_data,
  output logic bridge_enable,
  output logic [31:0] driver_status_word
);
  localparam int CW = $clog2(STST_CYCLES + 1);

  logic [CW-1:0] idle_cnt_q;
  logic stst_q;
  logic chop_q;
  logic [4:0] cs_q;
  logic [3:0] temp_q;
  logic [1:0] ol_q;
  logic ot_q;
  logic otpw_q;
  mdsf_therm_t therm_q;
  logic [31:0] word_d;
  logic drv_off;

  mdsf_short_if sif();

  assign drv_off = (chopper_off_time == MDSF_OFF_TIME_OFF) || enable_input_n;
  assign sif.detect = {lowside_short[1], lowside_short[0], ground_short[1], ground_short[0]};
  assign sif.chop_quiet = chop_quiet;
  assign sif.clear = drv_off;

  mdsf_short_latch u_short (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .sif(sif)
  );

  // standstill timer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      idle_cnt_q <= '0;
      stst_q <= 1'b0;
    end else if (step_pulse) begin
      idle_cnt_q <= '0;
      stst_q <= 1'b0;
    end else if (idle_cnt_q == CW'(STST_CYCLES - 1)) begin
      stst_q <= 1'b1;
    end else begin
      idle_cnt_q <= idle_cnt_q + CW'(1);
    end
  end

  // live indicators
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      chop_q <= 1'b0;
      cs_q <= 5'h0;
      temp_q <= 4'h0;
      ol_q <= 2'h0;
      otpw_q <= 1'b0;
    end else begin
      chop_q <= chop_quiet;
      cs_q <= current_scale;
      temp_q <= temp_cmp;
      ol_q <= open_load;
      otpw_q <= prewarn_limit;
    end
  end

  // thermal shutdown, one shared state for both bridges
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      therm_q <= MDSF_TH_RUN;
      ot_q <= 1'b0;
    end else begin
      ot_q <= overtemp_limit;
      case (therm_q)
        MDSF_TH_RUN: begin
          if (overtemp_limit) begin
            therm_q <= MDSF_TH_SHUT;
          end
        end
        MDSF_TH_SHUT: begin
          if (!overtemp_limit) begin
            therm_q <= MDSF_TH_COOL;
          end
        end
        MDSF_TH_COOL: begin
          if (overtemp_limit) begin
            therm_q <= MDSF_TH_SHUT;
          end else if (!prewarn_limit) begin
            therm_q <= MDSF_TH_RUN;
          end
        end
        default: begin
          therm_q <= MDSF_TH_RUN;
        end
      endcase
    end
  end

  // bridge off on a latched short of the active chopper mode or thermal shutdown; open load has no effect
  assign bridge_enable = !drv_off && (sif.flags == 4'h0) && (therm_q == MDSF_TH_RUN);

  always_comb begin
    word_d = MDSF_STATUS_RESET;
    word_d[MDSF_STST_BIT] = stst_q;
    word_d[MDSF_CHOP_BIT] = chop_q;
    word_d[MDSF_CS_HI:MDSF_CS_LO] = cs_q;
    word_d[MDSF_TEMP_CMP_HIGHEST_BIT] = temp_q[3];
    word_d[MDSF_TEMP_CMP_HIGH_BIT] = temp_q[2];
    word_d[MDSF_TEMP_CMP_MID_BIT] = temp_q[1];
    word_d[MDSF_TEMP_CMP_LOW_BIT] = temp_q[0];
    word_d[MDSF_OLB_BIT] = ol_q[1];
    word_d[MDSF_OLA_BIT] = ol_q[0];
    word_d[MDSF_LSB_BIT] = sif.flags[3];
    word_d[MDSF_LSA_BIT] = sif.flags[2];
    word_d[MDSF_GSB_BIT] = sif.flags[1];
    word_d[MDSF_GSA_BIT] = sif.flags[0];
    word_d[MDSF_OT_BIT] = ot_q;
    word_d[MDSF_OTPW_BIT] = otpw_q;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      driver_status_word <= MDSF_STATUS_RESET;
      rd_data <= MDSF_STATUS_RESET;
    end else begin
      driver_status_word <= word_d;
      if (rd_en) begin
        rd_data <= (rd_addr == MDSF_STATUS_ADDR) ? word_d : 32'h0000_0000;
      end
    end
  end

  stst_timer_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    step_pulse |=> !stst_q)
    else $error("standstill set right after step");
  stst_count_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (stst_q && !$past(stst_q)) |-> idle_cnt_q == CW'(STST_CYCLES - 1))
    else $error("standstill set at wrong count");
  chop_bit_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    chop_quiet |=> ##1 driver_status_word[MDSF_CHOP_BIT] || !$past(chop_q))
    else $error("chopper bit wrong");
  cs_field_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    1'b1 |=> ##1 driver_status_word[MDSF_CS_HI:MDSF_CS_LO] == $past(current_scale, 2))
    else $error("current scale field wrong");
  temp_bits_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    1'b1 |=> ##1 driver_status_word[MDSF_TEMP_CMP_HIGHEST_BIT:MDSF_TEMP_CMP_LOW_BIT] == $past(temp_cmp, 2))
    else $error("temperature bits wrong");
  open_load_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (open_load != 2'h0 && !drv_off && sif.flags == 4'h0 && therm_q == MDSF_TH_RUN)
      |-> bridge_enable)
    else $error("open load disabled bridge");
  short_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (lowside_short != 2'h0 && !drv_off) |=> !bridge_enable)
    else $error("lowside short left bridge on");
  gnd_short_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ground_short[1] && !drv_off) |=> ##1 driver_status_word[MDSF_GSB_BIT])
    else $error("ground short flag missing");
  therm_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (therm_q == MDSF_TH_COOL && prewarn_limit) |-> !bridge_enable)
    else $error("bridge on before prewarn cleared");
  prewarn_bit_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    prewarn_limit |=> ##1 driver_status_word[MDSF_OTPW_BIT])
    else $error("prewarning bit missing");
  reserved_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    driver_status_word[29:21] == 9'h0 && driver_status_word[15:12] == 4'h0)
    else $error("reserved bits nonzero");

  // standstill checks
  stst_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    step_pulse |=> ##1 !driver_status_word[MDSF_STST_BIT])
    else $error("standstill bit not cleared by step");
  stst_bit_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    stst_q |=> driver_status_word[MDSF_STST_BIT])
    else $error("standstill bit missing in word");
  stst_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (stst_q && !step_pulse) |=> stst_q)
    else $error("standstill dropped without step");
  idle_count_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!step_pulse && !stst_q) |=> (stst_q || idle_cnt_q == $past(idle_cnt_q) + CW'(1)))
    else $error("idle counter did not advance");
  step_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    step_pulse |=> idle_cnt_q == '0)
    else $error("idle counter not restarted by step");

  // live field checks
  chop_low_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !chop_quiet |=> ##1 !driver_status_word[MDSF_CHOP_BIT])
    else $error("chopper bit set for current chopper");
  ol_field_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    1'b1 |=> ##1 driver_status_word[MDSF_OLB_BIT:MDSF_OLA_BIT] == $past(open_load, 2))
    else $error("open load bits wrong");
  ot_bit_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    1'b1 |=> ##1 driver_status_word[MDSF_OT_BIT] == $past(overtemp_limit, 2))
    else $error("overtemperature bit wrong");
  prewarn_low_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !prewarn_limit |=> ##1 !driver_status_word[MDSF_OTPW_BIT])
    else $error("prewarning bit set without threshold");

  // thermal checks
  shut_entry_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (therm_q == MDSF_TH_RUN && overtemp_limit) |=> therm_q == MDSF_TH_SHUT)
    else $error("overtemp did not enter shutdown");
  shut_bridge_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    therm_q == MDSF_TH_SHUT |-> !bridge_enable)
    else $error("bridge on during shutdown");
  shut_stay_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (therm_q == MDSF_TH_SHUT && overtemp_limit) |=> therm_q == MDSF_TH_SHUT)
    else $error("shutdown left while overtemp");
  cool_exit_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (therm_q == MDSF_TH_COOL && !overtemp_limit && !prewarn_limit) |=> therm_q == MDSF_TH_RUN)
    else $error("bridges not released after cooling");
  cool_wait_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (therm_q == MDSF_TH_COOL && !overtemp_limit && prewarn_limit) |=> therm_q == MDSF_TH_COOL)
    else $error("cooling left while prewarn high");
  therm_legal_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    therm_q == MDSF_TH_RUN || therm_q == MDSF_TH_SHUT || therm_q == MDSF_TH_COOL)
    else $error("thermal state illegal");

  // short checks
  off_bridge_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    drv_off |-> !bridge_enable)
    else $error("bridge on while driver off");
  off_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    drv_off |=> sif.flags == 4'h0)
    else $error("short flags kept while driver off");
  gnd_phase_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ground_short[0] && !drv_off && !chop_quiet) ##1 !chop_quiet
      |=> driver_status_word[MDSF_GSA_BIT])
    else $error("ground short phase a flag missing");
  lowside_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (lowside_short[1] && !drv_off && !chop_quiet) ##1 !chop_quiet
      |=> driver_status_word[MDSF_LSB_BIT])
    else $error("lowside short phase b flag missing");
  quiet_short_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (lowside_short[0] && !drv_off && chop_quiet) ##1 chop_quiet
      |=> driver_status_word[MDSF_LSA_BIT])
    else $error("quiet mode short flag missing");
  quiet_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!chop_quiet && !drv_off) |=> $stable(u_short.quiet_q))
    else $error("quiet flags changed in current mode");
  curr_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (chop_quiet && !drv_off) |=> $stable(u_short.curr_q))
    else $error("current flags changed in quiet mode");
  short_bridge_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ground_short != 2'h0 && !drv_off) ##1 ($stable(chop_quiet) && !drv_off)
      |-> !bridge_enable)
    else $error("ground short left bridge on");
  run_bridge_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (therm_q == MDSF_TH_RUN && !drv_off && sif.flags == 4'h0) |-> bridge_enable)
    else $error("bridge off without cause");

  // read port checks
  rd_map_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rd_en && rd_addr != MDSF_STATUS_ADDR) |=> rd_data == 32'h0000_0000)
    else $error("unmapped read not zero");
  rd_word_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rd_en && rd_addr == MDSF_STATUS_ADDR) |=> rd_data == $past(word_d))
    else $error("status read data wrong");
  rd_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !rd_en |=> $stable(rd_data))
    else $error("read data changed without read");

  rd_status_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    rd_en && rd_addr == MDSF_STATUS_ADDR && stst_q);
  stst_seen_c: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(stst_q));
  therm_cycle_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    therm_q == MDSF_TH_COOL ##1 therm_q == MDSF_TH_RUN);
  short_clear_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    sif.flags != 4'h0 ##1 sif.clear);
endmodule

/* File: mdsf_host_model.sv */
// host model: reads registers through the status read port
`timescale 1ns/1ps
module mdsf_host_model (
  input wire logic clk_sys,
  input wire logic [31:0] rd_data,
  output logic rd_en,
  output logic [6:0] rd_addr
);
  initial begin
    rd_en = 1'b0;
    rd_addr = 7'h00;
  end
  // request held over the taking edge, data taken once it has landed
  task automatic read(input logic [6:0] a, output logic [31:0] d);
    @(negedge clk_sys);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge clk_sys);
    rd_en = 1'b0;
    rd_addr = ~a;
    @(negedge clk_sys);
    d = rd_data;
  endtask
endmodule

/* File: tb_top.sv */
// testbench: random and corner stimulus for the driver status block
`timescale 1ns/1ps
module tb_top;
  import mdsf_pkg::*;
  localparam int STST = 16;
  logic clk_sys, rstn, step_pulse, chop_quiet, overtemp_limit, prewarn_limit;
  logic enable_input_n, rd_en, bridge_enable;
  logic [4:0] current_scale, chopper_off_time;
  logic [3:0] temp_cmp;
  logic [1:0] open_load, lowside_short, ground_short;
  logic [6:0] rd_addr;
  logic [31:0] rd_data, driver_status_word, rv;
  logic [3:0] sh [2];
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  mdsf_status #(.STST_CYCLES(STST)) mdsf_status_i (.clk_sys, .rstn, .step_pulse, .chop_quiet,
    .current_scale, .temp_cmp, .open_load, .lowside_short, .ground_short, .overtemp_limit,
    .prewarn_limit, .chopper_off_time, .enable_input_n, .rd_en, .rd_addr, .rd_data,
    .bridge_enable, .driver_status_word);
  mdsf_host_model mdsf_host_model_i (.clk_sys, .rd_data, .rd_en, .rd_addr);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [31:0] exp_w(input logic st);
    return {st, chop_quiet, 9'h000, current_scale, 4'h0, temp_cmp, open_load,
      sh[chop_quiet], overtemp_limit, prewarn_limit};
  endfunction
  task automatic look(input logic st, input logic br);
    repeat (3) @(negedge clk_sys);
    chk(driver_status_word, exp_w(st));
    chk({31'h0, bridge_enable}, {31'h0, br});
  endtask
  initial begin
    rstn = 1'b0;
    step_pulse = 1'b0;
    chop_quiet = 1'b0;
    overtemp_limit = 1'b0;
    prewarn_limit = 1'b0;
    enable_input_n = 1'b0;
    chopper_off_time = 5'h3;
    {current_scale, temp_cmp, open_load, lowside_short, ground_short} = 15'h0;
    sh[0] = 4'h0;
    sh[1] = 4'h0;
    void'($urandom(32'hAC136E8E));
    repeat (2) @(negedge clk_sys);
    chk(driver_status_word, 32'h0);
    rstn = 1'b1;
    for (int i = 0; i < 24; i++) begin
      {chop_quiet, current_scale, temp_cmp, open_load} = 12'($urandom);
      step_pulse = 1'b1;
      @(negedge clk_sys);
      step_pulse = 1'b0;
      look(1'b0, 1'b1);
      mdsf_host_model_i.read(MDSF_STATUS_ADDR, rv);
      chk(rv, exp_w(1'b0));
      mdsf_host_model_i.read(7'($urandom) | 7'h70, rv);
      chk(rv, 32'h0);
    end
    chop_quiet = 1'b0;
    step_pulse = 1'b1;
    @(negedge clk_sys);
    step_pulse = 1'b0;
    look(1'b0, 1'b1);
    repeat (STST) @(negedge clk_sys);
    look(1'b1, 1'b1);
    for (int b = 0; b < 4; b++) begin
      {lowside_short, ground_short} = 4'(1 << b);
      @(negedge clk_sys);
      {lowside_short, ground_short} = 4'h0;
      sh[0] = 4'(1 << b);
      look(1'b1, 1'b0);
      chop_quiet = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk(driver_status_word, exp_w(1'b1));
      chop_quiet = 1'b0;
      look(1'b1, 1'b0);
      if (b[0])
        enable_input_n = 1'b1;
      else
        chopper_off_time = MDSF_OFF_TIME_OFF;
      @(negedge clk_sys);
      enable_input_n = 1'b0;
      chopper_off_time = 5'h3;
      sh[0] = 4'h0;
      look(1'b1, 1'b1);
    end
    prewarn_limit = 1'b1;
    look(1'b1, 1'b1);
    overtemp_limit = 1'b1;
    look(1'b1, 1'b0);
    overtemp_limit = 1'b0;
    look(1'b1, 1'b0);
    prewarn_limit = 1'b0;
    look(1'b1, 1'b1);
    summarize();
  end
endmodule
